// >>> logic/adcc_pkg.sv
package adcc_pkg;
  // register byte addresses on the byte-wide internal bus
  localparam logic [15:0] ADDR_RESULT_A  = 16'hFEE0;
  localparam logic [15:0] ADDR_RESULT_D_LO = 16'hFEE7;
  localparam logic [15:0] ADDR_CTRL_STAT = 16'hFEE8;
  localparam logic [15:0] ADDR_TRIG_CTRL = 16'hFEE9;
  // control/status field positions
  localparam int BIT_END_FLAG  = 7;
  localparam int BIT_IRQ_EN    = 6;
  localparam int BIT_RUN       = 5;
  localparam int BIT_SCAN      = 4;
  localparam int BIT_SPEED     = 3;
  localparam int BIT_GROUP     = 2;
  localparam int BIT_TRIG_EN   = 7;
  // reset values
  localparam logic [7:0]  CTRL_STAT_RST = 8'h00;
  localparam logic [7:0]  TRIG_CTRL_RST = 8'h7F;
  localparam logic [9:0]  RESULT_RST    = 10'h000;
  // conversion timing in states: first conversion worst case, later scan fixed
  localparam logic [8:0]  FIRST_SLOW = 9'h112; // 274
  localparam logic [8:0]  FIRST_FAST = 9'h08A; // 138
  localparam logic [8:0]  NEXT_SLOW  = 9'h100; // 256
  localparam logic [8:0]  NEXT_FAST  = 9'h080; // 128

  // bus access request
  typedef struct packed {
    logic        rd;
    logic        wr;
    logic [15:0] addr;
    logic [7:0]  wdata;
  } adcc_bus_t;

  // request to the analog core
  typedef struct packed {
    logic       start;
    logic [2:0] channel;
    logic [8:0] states;
  } adcc_core_req_t;
endpackage

// >>> logic/adcc_top.sv
`timescale 1ns/10ps
module adcc_top
  import adcc_pkg::*;
(
  input  wire logic            core_clk,
  input  wire logic            arst_n,
  input  wire logic            standby,
  input  wire adcc_bus_t       bus,
  output logic      [7:0]      rdata,
  input  wire logic            transfer_controller_service,
  input  wire logic            ext_trigger_in_n,
  output adcc_core_req_t       core_req,
  input  wire logic            core_done,
  input  wire logic [9:0]      core_result,
  output logic                 conversion_end_irq
);
  // control/status fields
  logic       end_flag;
  logic       irq_en;
  logic       run;
  logic       scan;
  logic       speed;
  logic [2:0] chsel;
  logic       trig_en;
  logic       flag_seen;   // end flag was read while set
  logic [9:0] result [4];
  logic [7:0] temp_lo;
  logic [1:0] pos;         // position within group being converted
  logic       busy;
  logic       first;       // next conversion is the first of a run
  logic [2:0] trig_sync;
  logic       trig_level;  // filtered pin level, follows once flops two and three agree

  // address decode
  wire        wr_cs      = bus.wr && bus.addr == ADDR_CTRL_STAT;
  wire        rd_cs      = bus.rd && bus.addr == ADDR_CTRL_STAT;
  wire        wr_tc      = bus.wr && bus.addr == ADDR_TRIG_CTRL;
  wire        in_result  = bus.addr >= ADDR_RESULT_A && bus.addr <= ADDR_RESULT_D_LO;
  wire [15:0] res_off    = bus.addr - ADDR_RESULT_A;
  wire [1:0]  res_idx    = res_off[2:1];
  wire        res_hi_rd  = bus.rd && in_result && !res_off[0];
  wire [7:0]  cs_val     = {end_flag, irq_en, run, scan, speed, chsel};
  wire [7:0]  tc_val     = {trig_en, TRIG_CTRL_RST[6:0]};

  // trigger: three flops, fall counts when second and third agree on low
  wire        trig_fall  = trig_en && trig_level && !trig_sync[1] && !trig_sync[2];
  wire        last_pos   = (pos == chsel[1:0]) || !scan;
  wire        done_ev    = busy && core_done;
  wire        set_flag   = done_ev && last_pos;
  wire        clr_flag   = (wr_cs && !bus.wdata[BIT_END_FLAG] && flag_seen)
                           || transfer_controller_service;
  wire        run_wr     = wr_cs ? bus.wdata[BIT_RUN] : run;
  wire        next_run   = trig_fall || (run_wr && !(done_ev && !scan));
  wire [1:0]  start_pos  = scan ? 2'h0 : chsel[1:0];

  assign conversion_end_irq = end_flag && irq_en;

  // read data mux
  always_comb begin
    rdata = 8'h00;
    if (rd_cs)
      rdata = cs_val;
    else if (bus.rd && bus.addr == ADDR_TRIG_CTRL)
      rdata = tc_val;
    else if (res_hi_rd)
      rdata = result[res_idx][9:2];
    else if (bus.rd && in_result)
      rdata = temp_lo;
  end

  // trigger synchroniser; a single glitchy sample cannot start a conversion
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      trig_sync  <= 3'h7;
      trig_level <= 1'b1;
    end else begin
      trig_sync <= {trig_sync[1:0], ext_trigger_in_n};
      if (trig_sync[1] == trig_sync[2])
        trig_level <= trig_sync[2];
    end
  end

  // control registers; the hardware set wins over a software clear
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      {end_flag, irq_en, run, scan, speed, chsel} <= CTRL_STAT_RST;
      trig_en   <= TRIG_CTRL_RST[7];
      flag_seen <= 1'b0;
    end else if (standby) begin
      {end_flag, irq_en, run, scan, speed, chsel} <= CTRL_STAT_RST;
      trig_en   <= TRIG_CTRL_RST[7];
      flag_seen <= 1'b0;
    end else begin
      end_flag  <= set_flag || (end_flag && !clr_flag);
      flag_seen <= rd_cs ? end_flag : (flag_seen && !clr_flag && end_flag);
      run       <= next_run;
      if (wr_cs) begin
        irq_en <= bus.wdata[BIT_IRQ_EN];
        scan   <= bus.wdata[BIT_SCAN];
        speed  <= bus.wdata[BIT_SPEED];
        chsel  <= bus.wdata[BIT_GROUP:0];
      end
      if (wr_tc)
        trig_en <= bus.wdata[BIT_TRIG_EN];
    end
  end

  // sequencer for the analog core: keeps one conversion in flight
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      busy     <= 1'b0;
      first    <= 1'b1;
      pos      <= 2'h0;
      core_req <= '0;
    end else if (standby || !run) begin
      busy     <= 1'b0;
      first    <= 1'b1;
      pos      <= 2'h0;
      core_req <= '0;
    end else begin
      core_req.start <= 1'b0;
      if (!busy || (done_ev && scan)) begin
        busy             <= 1'b1;
        first            <= 1'b0;
        pos              <= !busy ? start_pos : (last_pos ? 2'h0 : pos + 2'h1);
        core_req.start   <= 1'b1;
        core_req.channel <= {chsel[2], !busy ? start_pos
                                             : (last_pos ? 2'h0 : pos + 2'h1)};
        core_req.states  <= first ? (speed ? FIRST_FAST : FIRST_SLOW)
                                  : (speed ? NEXT_FAST : NEXT_SLOW);
      end else if (done_ev) begin
        busy  <= 1'b0;
        first <= 1'b1;  // a trigger restart after single mode gets first-conversion budget
      end
    end
  end

  // result registers and temporary latch
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      for (int i = 0; i < 4; i++) result[i] <= RESULT_RST;
      temp_lo <= 8'h00;
    end else if (standby) begin
      for (int i = 0; i < 4; i++) result[i] <= RESULT_RST;
      temp_lo <= 8'h00;
    end else begin
      if (done_ev)
        result[pos] <= core_result;
      if (res_hi_rd)
        temp_lo <= {result[res_idx][1:0], 6'h00};
    end
  end

  AST_IRQ: assert property (@(posedge core_clk) disable iff (!arst_n)
    conversion_end_irq == (end_flag && irq_en)) else $error("irq mismatch");
  AST_SET: assert property (@(posedge core_clk) disable iff (!arst_n)
    set_flag && !standby |=> end_flag) else $error("end flag not set");
  AST_ONEW: assert property (@(posedge core_clk) disable iff (!arst_n)
    !end_flag && !set_flag && !standby |=> !end_flag) else $error("flag set by sw");
  AST_XFER_CLR: assert property (@(posedge core_clk) disable iff (!arst_n)
    transfer_controller_service && !set_flag |=> !end_flag) else $error("service clear failed");
  AST_SINGLE: assert property (@(posedge core_clk) disable iff (!arst_n)
    done_ev && !scan && !trig_fall && !standby |=> !run) else $error("run kept");
  AST_TRIG: assert property (@(posedge core_clk) disable iff (!arst_n)
    trig_fall && !standby |=> run) else $error("trigger ignored");
  AST_TC: assert property (@(posedge core_clk) disable iff (!arst_n)
    tc_val[6:0] == 7'h7F) else $error("reserved bits wrong");
  AST_LOW: assert property (@(posedge core_clk) disable iff (!arst_n)
    temp_lo[5:0] == 6'h00) else $error("low bits nonzero");
  AST_STBY: assert property (@(posedge core_clk) disable iff (!arst_n)
    standby |=> result[0] == RESULT_RST && cs_val == CTRL_STAT_RST) else $error("standby");

  // start to the core is a single-cycle pulse
  AST_START_PULSE: assert property (@(posedge core_clk) disable iff (!arst_n)
    core_req.start |=> !core_req.start) else $error("start held");

  // a stopped converter issues no start
  AST_START_IDLE: assert property (@(posedge core_clk) disable iff (!arst_n)
    !run |=> !core_req.start) else $error("start while halted");

  // scan keeps running after each done
  AST_SCAN_KEEP: assert property (@(posedge core_clk) disable iff (!arst_n)
    done_ev && scan && run && !wr_cs && !standby |=> run) else $error("scan stopped");

  // scan begins at the group's first channel
  AST_SCAN_FIRST: assert property (@(posedge core_clk) disable iff (!arst_n)
    !busy && run && scan && !standby |=> core_req.channel[1:0] == 2'h0)
    else $error("scan start channel");

  // single mode converts the selected channel
  AST_SINGLE_CH: assert property (@(posedge core_clk) disable iff (!arst_n)
    !busy && run && !scan && !wr_cs && !standby |=> core_req.channel == chsel)
    else $error("single channel");

  // first conversion of a run gets the worst-case budget
  AST_FIRST_TIME: assert property (@(posedge core_clk) disable iff (!arst_n)
    !busy && run && !wr_cs && !standby |=>
    core_req.states == (speed ? FIRST_FAST : FIRST_SLOW)) else $error("first budget");

  // later scan conversions get the fixed budget
  AST_NEXT_TIME: assert property (@(posedge core_clk) disable iff (!arst_n)
    done_ev && scan && run && !wr_cs && !standby |=>
    core_req.states == (speed ? NEXT_FAST : NEXT_SLOW)) else $error("next budget");

  // scan wraps to the first channel after the last one
  AST_SCAN_WRAP: assert property (@(posedge core_clk) disable iff (!arst_n)
    done_ev && scan && last_pos && run && !standby |=> core_req.channel[1:0] == 2'h0)
    else $error("scan wrap");

  // next channel starts as soon as the previous finishes
  AST_SCAN_STEP: assert property (@(posedge core_clk) disable iff (!arst_n)
    done_ev && scan && !last_pos && run && !standby |=> core_req.start)
    else $error("scan gap");

  // without a read while set, the flag survives a zero write
  AST_CLR_NEED_READ: assert property (@(posedge core_clk) disable iff (!arst_n)
    end_flag && !flag_seen && !transfer_controller_service && !standby |=> end_flag)
    else $error("flag cleared without read");

  // hardware set wins over a clear in the same cycle
  AST_SET_WINS: assert property (@(posedge core_clk) disable iff (!arst_n)
    set_flag && clr_flag && !standby |=> end_flag) else $error("clear beat set");

  // writing zero to the run bit halts the converter
  AST_RUN_DROP: assert property (@(posedge core_clk) disable iff (!arst_n)
    wr_cs && !bus.wdata[BIT_RUN] && !trig_fall && !standby |=> !run)
    else $error("run not halted");

  // lower byte reads come from the latch
  AST_RD_LO: assert property (@(posedge core_clk) disable iff (!arst_n)
    bus.rd && in_result && res_off[0] |-> rdata == temp_lo) else $error("low read");

  // upper byte reads come from the live register
  AST_RD_HI: assert property (@(posedge core_clk) disable iff (!arst_n)
    res_hi_rd |-> rdata == result[res_idx][9:2]) else $error("high read");

  // control/status reads show the live fields
  AST_RD_CS: assert property (@(posedge core_clk) disable iff (!arst_n)
    rd_cs |-> rdata == cs_val) else $error("status read");

  // trigger control reads keep reserved bits at one
  AST_RD_TC: assert property (@(posedge core_clk) disable iff (!arst_n)
    bus.rd && bus.addr == ADDR_TRIG_CTRL |-> rdata[6:0] == 7'h7F)
    else $error("trigger read");

  // request stays quiet while disabled
  AST_IRQ_OFF: assert property (@(posedge core_clk) disable iff (!arst_n)
    !irq_en |-> !conversion_end_irq) else $error("irq while disabled");

  // standby clears trigger enable and idles the sequencer
  AST_STBY_TC: assert property (@(posedge core_clk) disable iff (!arst_n)
    standby |=> !trig_en && !busy && !core_req.start) else $error("standby idle");

  // standby clears the other result registers too
  AST_STBY_RES: assert property (@(posedge core_clk) disable iff (!arst_n)
    standby |=> result[1] == RESULT_RST && result[2] == RESULT_RST && result[3] == RESULT_RST)
    else $error("standby results");

  COV_XFER: cover property (@(posedge core_clk) transfer_controller_service && end_flag);
  COV_SCAN: cover property (@(posedge core_clk) set_flag && scan);
  COV_SINGLE: cover property (@(posedge core_clk) set_flag && !scan);
  COV_TRIG: cover property (@(posedge core_clk) trig_fall);
endmodule

// >>> verification/adc_control_and_result_regs_tb.sv
`timescale 1ns/10ps
module adc_control_and_result_regs_tb
  import adcc_pkg::*;
;
  localparam logic [15:0] CS = ADDR_CTRL_STAT;
  localparam logic [15:0] TC = ADDR_TRIG_CTRL;
  logic           core_clk = 1'b0;
  logic           arst_n, standby, transfer_controller_service, ext_trigger_in_n, core_done, irq;
  adcc_bus_t      bus;
  adcc_core_req_t core_req;
  logic [7:0]     rdata, v;
  logic [9:0]     core_result;
  int             failures, check_count;

  always #5 core_clk = ~core_clk;

  adcc_top i_dut (.core_clk(core_clk), .arst_n(arst_n), .standby(standby), .bus(bus),
    .rdata(rdata), .transfer_controller_service(transfer_controller_service),
    .ext_trigger_in_n(ext_trigger_in_n),
    .core_req(core_req), .core_done(core_done), .core_result(core_result),
    .conversion_end_irq(irq));
  adcc_core_model i_core (.core_clk(core_clk), .arst_n(arst_n), .core_req(core_req),
    .core_done(core_done), .core_result(core_result));

  task automatic end_of_test();
    if (failures == 0 && check_count > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp) begin
      failures++;
      $display("Error %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // bus requests change at the falling edge and are taken at the rising one
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(negedge core_clk) bus = '{1'b0, 1'b1, a, d};
    @(negedge core_clk) bus = '0;
  endtask
  task automatic rd(input logic [15:0] a, output logic [7:0] d);
    @(negedge core_clk) bus = '{1'b1, 1'b0, a, 8'h00};
    #4 d = rdata;  // settled read data just before the taking edge
    @(negedge core_clk) bus = '0;
  endtask
  task automatic rchk(input logic [15:0] a, input logic [7:0] exp);
    logic [7:0] d;
    rd(a, d);
    chk(d, exp);
  endtask
  // bounded wait so a dead converter cannot hang the run
  task automatic wait_irq();
    int n;
    n = 0;
    while (irq !== 1'b1 && n < 2000) begin
      @(negedge core_clk);
      n++;
    end
    if (n >= 2000) begin
      failures++;
      $display("Error %0t: no end interrupt", $time);
      end_of_test();
    end
  endtask
  task automatic fall();
    @(negedge core_clk) ext_trigger_in_n = 1'b0;
    repeat (4) @(negedge core_clk);
    ext_trigger_in_n = 1'b1;
  endtask

  initial begin
    {bus, standby, transfer_controller_service, arst_n, failures, check_count} = '0;
    ext_trigger_in_n = 1'b1;
    repeat (5) @(negedge core_clk);
    arst_n = 1'b1;
    rchk(CS, 8'h00);
    rchk(TC, 8'h7F);
    rchk(ADDR_RESULT_A, 8'h00);
    wr(TC, 8'h00);
    rchk(TC, 8'h7F);
    fall();
    rchk(CS, 8'h00);
    // single conversion of input 5, fast, request enabled
    wr(CS, 8'h6D);
    wait_irq();
    wr(CS, 8'h4D);
    chk({7'h00, irq}, 8'h01);
    rchk(CS, 8'hCD);
    wr(CS, 8'h4D);
    rchk(CS, 8'h4D);
    chk({7'h00, irq}, 8'h00);
    rchk(16'hFEE2, 8'hAD);
    rchk(16'hFEE3, 8'h40);
    rchk(16'hFEE1, 8'h40);
    // scan of inputs 0 to 2, slow
    wr(CS, 8'h72);
    wait_irq();
    rchk(CS, 8'hF2);
    @(negedge core_clk) transfer_controller_service = 1'b1;
    @(negedge core_clk) transfer_controller_service = 1'b0;
    rchk(CS, 8'h72);
    rchk(ADDR_RESULT_A, 8'h0D);
    rchk(16'hFEE2, 8'h2D);
    rchk(16'hFEE4, 8'h4D);
    rchk(16'hFEE5, 8'h40);
    rchk(16'hFEE6, 8'h00);
    wr(CS, 8'h00);
    // external trigger enabled
    wr(TC, 8'hFF);
    rchk(TC, 8'hFF);
    fall();
    rd(CS, v);
    chk(v & 8'h20, 8'h20);
    @(negedge core_clk) standby = 1'b1;
    @(negedge core_clk) standby = 1'b0;
    rchk(CS, 8'h00);
    rchk(TC, 8'h7F);
    rchk(16'hFEE2, 8'h00);
    end_of_test();
  end
endmodule

// >>> verification/adcc_core_model.sv
`timescale 1ns/10ps
module adcc_core_model
  import adcc_pkg::*;
(
  input  wire logic           core_clk,
  input  wire logic           arst_n,
  input  wire adcc_core_req_t core_req,
  output logic                core_done,
  output logic [9:0]          core_result
);
  logic [8:0] cnt;
  logic [2:0] ch;
  logic       busy;
  // odd channels answer fast, even ones slowly; result is unknowable between strobes
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      {cnt, ch, busy, core_done, core_result} <= '0;
    end else begin
      core_done <= 1'b0;
      core_result <= ~core_result;
      if (core_req.start) begin
        busy <= 1'b1;
        ch <= core_req.channel;
        cnt <= core_req.channel[0] ? 9'h005 : core_req.states >> 3;
      end else if (busy && cnt == 9'h000) begin
        busy <= 1'b0;
        core_done <= 1'b1;
        core_result <= {ch, 7'h35};
      end else if (busy) begin
        cnt <= cnt - 9'h001;
      end
    end
  end
endmodule
